// *** hdl/wkes_regs.svh ***
/*
 * Register offsets, field positions, valid-bit masks and reset values
 * of the wake-up event status and enable block.
 * Assumes byte addresses on an 8-bit Wishbone address, one 32-bit
 * word per register.
 */
`ifndef WKES_REGS_SVH
`define WKES_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define WKES_OFS_STATUS 8'h14
`define WKES_OFS_ENABLE 8'h1c
`define WKES_OFS_TYPE 8'h20
`define WKES_OFS_HIBCTL 8'h24
`define WKES_OFS_MASK 8'h28

// ****************************************************************
// Bit positions in status and enable
// ****************************************************************
`define WKES_BIT_RTC 15
`define WKES_BIT_PWRBTN 14
`define WKES_BIT_USBDEV 13
`define WKES_BIT_USBHOST 12
`define WKES_BIT_MOUSE 11
`define WKES_BIT_KBD 10
`define WKES_BIT_ETH 9
`define WKES_GP_N 8
`define WKES_TYPE_W 4

// ****************************************************************
// Implemented bits and reset values
// ****************************************************************
`define WKES_STATUS_VALID 16'hfeff
`define WKES_ENABLE_VALID 16'hbeff
`define WKES_RST_STATUS 16'h0000
`define WKES_RST_ENABLE 16'h0000
`define WKES_RST_TYPE 32'h0000_0000
`define WKES_RST_MASK 16'h0000
`define WKES_RST_HIB 3'h0

`endif

// *** hdl/wkes_pkg.sv ***
/*
 * Types of the wake-up event block: wake condition codes and
 * hibernation request codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wkes_pkg;

    // ************************************************************
    // Wake condition of one general-purpose input
    // ************************************************************
    typedef enum logic [3:0] {
        WKES_WT_LOW = 4'h0,
        WKES_WT_HIGH = 4'h1,
        WKES_WT_FALL = 4'h2,
        WKES_WT_RISE = 4'h3,
        WKES_WT_EDGE = 4'h4
    } wkes_wtype_t;

    // ************************************************************
    // Hibernation request codes
    // ************************************************************
    typedef enum logic [2:0] {
        WKES_HIB_NONE = 3'h0,
        WKES_HIB_SUSPEND = 3'h1,
        WKES_HIB_SLEEP = 3'h3,
        WKES_HIB_SHUTDOWN = 3'h5
    } wkes_hib_t;

endpackage

// *** hdl/wkes_det_if.sv ***
/*
 * Carrier between the top and the wake condition detector.
 * Assumes one clock shared by both ends.
 */
interface wkes_det_if #(
    parameter int N = 8
);
    logic [N-1:0] level;
    logic [4*N-1:0] wtype;
    logic [N-1:0] hit;

    modport det (
        input level,
        input wtype,
        output hit
    );

    modport top (
        output level,
        output wtype,
        input hit
    );
endinterface

// *** hdl/wkes_sync.sv ***
/*
 * Two-stage synchroniser for pin inputs.
 * Assumes inputs asynchronous to clk_i; output is safe for logic.
 */
module wkes_sync #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule // wkes_sync

// *** hdl/wkes_detect.sv ***
/*
 * Per-input wake condition detector for the general-purpose sources.
 * Assumes levels already on clk_i; hit is combinational.
 */
`include "wkes_regs.svh"

module wkes_detect import wkes_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    wkes_det_if.det det
);
    localparam int N = `WKES_GP_N;
    logic [N-1:0] prev_reg;

    // Previous level, sampled every cycle with no reset of its own; hit is held low only while rst_i is high
    always_ff @(posedge clk_i) begin
        prev_reg <= det.level;
    end

    always_comb begin
        det.hit = '0;
        for (int i = 0; i < N; i++) begin
            case (wkes_wtype_t'(det.wtype[4*i +: 4]))
                WKES_WT_LOW: det.hit[i] = ~det.level[i];
                WKES_WT_HIGH: det.hit[i] = det.level[i];
                WKES_WT_FALL: det.hit[i] = prev_reg[i] & ~det.level[i];
                WKES_WT_RISE: det.hit[i] = ~prev_reg[i] & det.level[i];
                WKES_WT_EDGE: det.hit[i] = prev_reg[i] ^ det.level[i];
                default: det.hit[i] = 1'b0;
            endcase
        end
        if (rst_i) begin
            det.hit = '0;
        end
    end
endmodule // wkes_detect

// *** hdl/wkes_top.sv ***
/*
 * Wake-up event status and enable register bank, classic Wishbone
 * slave, with interrupt mask and hibernation request register.
 * Assumes internal sources on clk_i; power button and gp pins 2:0
 * asynchronous. por_i marks a power-up reset, resume_i its cause.
 */
// Contract
// - Status bit 15 records a real-time clock alarm wake-up.
// - Status bit 14 records a power button wake-up.
// - Status bits 13..9: USB device, USB host, mouse, keyboard, Ethernet.
// - Status bits 7:0 record the general-purpose wake-up events.
// - Status bits clear on writing one; writing zero keeps them.
// - Enable bit 15 makes the clock alarm a wake-up event.
// - Enable bits 13..9 gate those five sources; 14 and 8 reserved.
// - Enable bits 7:0 gate the general-purpose wake-up events.
// - Type register field decides what wakes from each gp input.
// - Power-up reset from resume clears the enable register.
// - Other power-up reset restores the programmed enable value.
// - Non power-up reset leaves the enable register untouched.
// - Gp positions 7:3 come from internal blocks in sleep.
// - Gp positions 2:0 come from external pins.
// - Type codes: low, high, falling, rising, either edge.
// - Hibernation field accepts 011 sleep, 001 suspend, 101 shutdown.

`include "wkes_regs.svh"

module wkes_top import wkes_pkg::*; #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic resume_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rtc_intr_i,
    input wire logic pwr_btn_i,
    input wire logic usb_dev_i,
    input wire logic usb_host_i,
    input wire logic mouse_i,
    input wire logic kbd_i,
    input wire logic eth_i,
    input wire logic [7:3] gp_int_i,
    input wire logic [2:0] gp_pin_i,
    output logic irq_o,
    output logic [2:0] hib_mode_o,
    output logic wake_o
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nv,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nv & m);
    endfunction

    function automatic logic hib_code_ok(input logic [2:0] code);
        hib_code_ok = (code == WKES_HIB_SLEEP) ||
                      (code == WKES_HIB_SUSPEND) ||
                      (code == WKES_HIB_SHUTDOWN);
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [15:0] enable_reg;
    logic [15:0] enable_keep_reg;
    logic [31:0] type_reg;
    logic [31:0] type_keep_reg;
    logic [15:0] mask_reg;
    logic [2:0] hib_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic irq_reg;
    logic wake_reg;
    logic [31:0] rd_data;
    logic [31:0] wmask;
    logic [ADR_W-1:0] adr_word;
    logic acc;
    logic wr_now;
    logic wr_status;
    logic wr_enable;
    logic wr_type;
    logic wr_hib;
    logic wr_mask;
    logic [3:0] pins_s;
    logic pwr_btn_s;
    logic [2:0] gp_pin_s;
    logic [15:0] event_vec;
    logic any_event;

    wkes_det_if #(.N(`WKES_GP_N)) det_bus ();

    // ************************************************************
    // Pin synchronisers and gp condition detector
    // ************************************************************
    wkes_sync #(.W(4)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({pwr_btn_i, gp_pin_i}),
        .sync_o(pins_s)
    );

    assign pwr_btn_s = pins_s[3];
    assign gp_pin_s = pins_s[2:0];

    assign det_bus.level = {gp_int_i, gp_pin_s};
    assign det_bus.wtype = type_reg;

    wkes_detect u_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .det(det_bus)
    );

    // ************************************************************
    // Wake-up events, gated by enable except the power button
    // ************************************************************
    always_comb begin
        event_vec = 16'h0000;
        event_vec[`WKES_BIT_RTC] = rtc_intr_i & enable_reg[`WKES_BIT_RTC];
        event_vec[`WKES_BIT_PWRBTN] = pwr_btn_s;
        event_vec[`WKES_BIT_USBDEV] =
            usb_dev_i & enable_reg[`WKES_BIT_USBDEV];
        event_vec[`WKES_BIT_USBHOST] =
            usb_host_i & enable_reg[`WKES_BIT_USBHOST];
        event_vec[`WKES_BIT_MOUSE] = mouse_i & enable_reg[`WKES_BIT_MOUSE];
        event_vec[`WKES_BIT_KBD] = kbd_i & enable_reg[`WKES_BIT_KBD];
        event_vec[`WKES_BIT_ETH] = eth_i & enable_reg[`WKES_BIT_ETH];
        event_vec[`WKES_GP_N-1:0] =
            det_bus.hit & enable_reg[`WKES_GP_N-1:0];
        if (rst_i || por_i) begin
            event_vec = 16'h0000;
        end
    end

    assign any_event = |event_vec;

    // ************************************************************
    // Wishbone decode
    // ************************************************************
    assign acc = wb_cyc_i & wb_stb_i;
    assign wr_now = acc & wb_we_i & ack_reg;
    assign wmask = byte_mask(wb_sel_i);
    assign adr_word = {wb_adr_i[ADR_W-1:2], 2'b00};

    always_comb begin
        wr_status = 1'b0;
        wr_enable = 1'b0;
        wr_type = 1'b0;
        wr_hib = 1'b0;
        wr_mask = 1'b0;
        if (adr_word == `WKES_OFS_STATUS) begin
            wr_status = wr_now;
        end else if (adr_word == `WKES_OFS_ENABLE) begin
            wr_enable = wr_now;
        end else if (adr_word == `WKES_OFS_TYPE) begin
            wr_type = wr_now;
        end else if (adr_word == `WKES_OFS_HIBCTL) begin
            wr_hib = wr_now;
        end else if (adr_word == `WKES_OFS_MASK) begin
            wr_mask = wr_now;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (adr_word == `WKES_OFS_STATUS) begin
            rd_data = {16'h0000, status_reg};
        end else if (adr_word == `WKES_OFS_ENABLE) begin
            rd_data = {16'h0000, enable_reg};
        end else if (adr_word == `WKES_OFS_TYPE) begin
            rd_data = type_reg;
        end else if (adr_word == `WKES_OFS_HIBCTL) begin
            rd_data = {29'h0000_0000, hib_reg};
        end else if (adr_word == `WKES_OFS_MASK) begin
            rd_data = {16'h0000, mask_reg};
        end
    end

    // One wait state; ack drops the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= acc & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (acc && !ack_reg && !wb_we_i) begin
            dat_reg <= rd_data;
        end
    end

    // ************************************************************
    // Status register
    // ************************************************************
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~(wb_dat_i[15:0] & wmask[15:0]);
        end
        status_next = status_next | event_vec;
        status_next = status_next & `WKES_STATUS_VALID;
    end

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            status_reg <= `WKES_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // ************************************************************
    // Enable and type registers, retained across all resets but a resume power-up reset
    // ************************************************************
    // Keep copies model the always-on storage
    always_ff @(posedge clk_i) begin
        if (por_i && resume_i) begin
            enable_keep_reg <= `WKES_RST_ENABLE;
        end else if (!por_i && wr_enable) begin
            enable_keep_reg <= 16'(merge({16'h0000, enable_reg},
                wb_dat_i, wmask)
                & {16'h0000, `WKES_ENABLE_VALID});
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            enable_reg <= resume_i ? `WKES_RST_ENABLE : enable_keep_reg;
        end else if (wr_enable) begin
            enable_reg <= 16'(merge({16'h0000, enable_reg}, wb_dat_i, wmask)
                & {16'h0000, `WKES_ENABLE_VALID});
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i && resume_i) begin
            type_keep_reg <= `WKES_RST_TYPE;
        end else if (!por_i && wr_type) begin
            type_keep_reg <= merge(type_reg, wb_dat_i, wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            type_reg <= resume_i ? `WKES_RST_TYPE : type_keep_reg;
        end else if (wr_type) begin
            type_reg <= merge(type_reg, wb_dat_i, wmask);
        end
    end

    // ************************************************************
    // Hibernation request and interrupt mask
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            hib_reg <= `WKES_RST_HIB;
        end else if (any_event) begin
            // Wake-up ends the hibernation request
            hib_reg <= WKES_HIB_NONE;
        end else if (wr_hib && wb_sel_i[0] && hib_code_ok(wb_dat_i[2:0])) begin
            hib_reg <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i || rst_i) begin
            mask_reg <= `WKES_RST_MASK;
        end else if (wr_mask) begin
            mask_reg <= 16'(merge({16'h0000, mask_reg}, wb_dat_i, wmask)
                & {16'h0000, `WKES_STATUS_VALID});
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i || rst_i) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & mask_reg);
            wake_reg <= any_event && (hib_reg != WKES_HIB_NONE);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;
    assign hib_mode_o = hib_reg;
    assign wake_o = wake_reg;

endmodule // wkes_top

// *** testbench/wkes_top_properties.sv ***
/* Port checker of the wake-up event register bank.
   Assumes a bind into wkes_top, one clock, active-high resets. */
`include "wkes_regs.svh"

module wkes_top_properties import wkes_pkg::*; #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic pwr_btn_i,
    input wire logic irq_o,
    input wire logic [2:0] hib_mode_o,
    input wire logic wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);

    // ********************
    // Bus and register properties
    // ********************
    logic hib_ok;
    assign hib_ok = wb_dat_i[2:0] inside {3'h1, 3'h3, 3'h5};

    sequence s_read(ofs);
        wb_ack_o && !wb_we_i && wb_adr_i == ofs;
    endsequence
    sequence s_hib_write;
        wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i == ADR_W'(`WKES_OFS_HIBCTL);
    endsequence

    chk_ack_one_wait: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_status_reserved: assert property (
        s_read(ADR_W'(`WKES_OFS_STATUS)) |->
        wb_dat_o[31:16] == 16'h0 && !wb_dat_o[8])
        else $error("status reserved bits not zero");
    chk_enable_reserved: assert property (
        s_read(ADR_W'(`WKES_OFS_ENABLE)) |->
        wb_dat_o[31:16] == 16'h0 && !wb_dat_o[14] && !wb_dat_o[8])
        else $error("enable reserved bits not zero");
    chk_unmapped_zero: assert property (
        s_read(ADR_W'(8'h30)) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_hib_legal: assert property (
        hib_mode_o inside {3'h0, 3'h1, 3'h3, 3'h5})
        else $error("illegal hibernation code");
    chk_hib_take: assert property (
        s_hib_write ##0 hib_ok |=> hib_mode_o == $past(wb_dat_i[2:0]))
        else $error("hibernation code not taken");
    chk_hib_refuse: assert property (
        s_hib_write ##0 !hib_ok |=> $stable(hib_mode_o))
        else $error("bad hibernation code taken");
    chk_wake_clears: assert property (
        wake_o |-> $past(hib_mode_o) != 3'h0 ##0 hib_mode_o == 3'h0
        ##1 !wake_o)
        else $error("wake pulse not tied to request");
    chk_button_wake: assert property (
        pwr_btn_i && hib_mode_o != 3'h0 |-> ##[1:5] wake_o)
        else $error("power button did not wake");
    chk_irq_hold: assert property (
        $fell(irq_o) |->
        $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
        else $error("irq fell without a write");
endmodule // wkes_top_properties

bind wkes_top wkes_top_properties #(.ADR_W(ADR_W)) props_u (.*);

// *** testbench/wkes_src_model.sv ***
/* Model of the wake-up sources: internal event lines and pins.
   Assumes the bench changes want_i right after a rising edge. */
module wkes_src_model (
    input wire logic clk_i,
    input wire logic [15:0] want_i,
    output logic [15:0] src_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i) begin
        src_o <= want_i;
    end
endmodule // wkes_src_model

// *** testbench/wkes_top_test.sv ***
/* Self-checking bench of the wake-up event register bank.
   Assumes the source model and the checker are compiled before. */
`include "wkes_regs.svh"

module wkes_top_test import wkes_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, por_i, resume_i, cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, wb_dat_o, ev;
    logic wb_ack_o, irq_o, wake_o;
    logic [2:0] hib_mode_o;
    logic [15:0] want, src;
    logic [5:0] exp_tbl [3] = '{6'b000001, 6'b011011, 6'b010111};
    wkes_hib_t codes [3] = '{WKES_HIB_SLEEP, WKES_HIB_SUSPEND,
        WKES_HIB_SHUTDOWN};
    int num_errors, n_checks, cycles, i, c, s, k, n;

    wkes_src_model src_u (.clk_i(clk_i), .want_i(want), .src_o(src));
    wkes_top #(.ADR_W(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .por_i(por_i), .resume_i(resume_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rtc_intr_i(src[15]), .pwr_btn_i(src[14]), .usb_dev_i(src[13]),
        .usb_host_i(src[12]), .mouse_i(src[11]), .kbd_i(src[10]),
        .eth_i(src[9]), .gp_int_i(src[7:3]), .gp_pin_i(src[2:0]),
        .irq_o(irq_o), .hib_mode_o(hib_mode_o), .wake_o(wake_o));

    // ********************
    // Clock, timeout and tasks
    // ********************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task tick(input int m);
        repeat (m) @(posedge clk_i);
    endtask

    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        rdat = wb_dat_o;
        if (t >= 20) num_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rdat);
    endtask

    task pulse(input int b);
        want[b] <= 1'b1;
        tick(6);
        want[b] <= 1'b0;
        tick(4);
    endtask

    task close_out;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ********************
    // Test sequence
    // ********************
    initial begin
        rst_i = 1'b1;
        por_i = 1'b1;
        resume_i = 1'b1;
        {cyc, stb, we, adr, wdat, want} = '0;
        sel = 4'hf;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("status", `WKES_OFS_STATUS, 32'h0);
        rd_chk("enable", `WKES_OFS_ENABLE, 32'h0);
        xfer(`WKES_OFS_TYPE, 1'b1, 32'h3333_3333);
        xfer(`WKES_OFS_ENABLE, 1'b1, 32'hffff_ffff);
        rd_chk("enable", `WKES_OFS_ENABLE, 32'h0000_beff);
        xfer(`WKES_OFS_STATUS, 1'b1, 32'hffff_ffff);
        rd_chk("status", `WKES_OFS_STATUS, 32'h0);
        rd_chk("unmapped", 8'h30, 32'h0);
        for (i = 15; i >= 0; i--) begin
            if (i == 8) continue;
            xfer(`WKES_OFS_ENABLE, 1'b1, 32'h0);
            pulse(i);
            ev = (i == 14) ? 32'h0000_4000 : 32'h0;
            rd_chk("gated", `WKES_OFS_STATUS, ev);
            xfer(`WKES_OFS_STATUS, 1'b1, 32'hffff);
            xfer(`WKES_OFS_ENABLE, 1'b1, 32'h1 << i);
            pulse(i);
            xfer(`WKES_OFS_STATUS, 1'b1, 32'h0);
            rd_chk("event", `WKES_OFS_STATUS, 32'h1 << i);
            xfer(`WKES_OFS_STATUS, 1'b1, 32'h1 << i);
            rd_chk("cleared", `WKES_OFS_STATUS, 32'h0);
        end
        for (c = 0; c < 6; c++) begin
            xfer(`WKES_OFS_TYPE, 1'b1, 32'(c) << 4);
            for (s = 0; s < 3; s++) begin
                xfer(`WKES_OFS_ENABLE, 1'b1, 32'h0);
                xfer(`WKES_OFS_STATUS, 1'b1, 32'hff);
                xfer(`WKES_OFS_ENABLE, 1'b1, 32'h2);
                if (s == 1) want[1] <= 1'b1;
                if (s == 2) want[1] <= 1'b0;
                tick(6);
                ev = 32'(exp_tbl[s][c]) << 1;
                rd_chk("type", `WKES_OFS_STATUS, ev);
            end
        end
        xfer(`WKES_OFS_ENABLE, 1'b1, 32'h8000);
        for (k = 0; k < 3; k++) begin
            xfer(`WKES_OFS_HIBCTL, 1'b1, 32'(codes[k]));
            chk("hib", 32'(codes[k]), 32'(hib_mode_o));
            want[k == 2 ? 14 : 15] <= 1'b1;
            n = 0;
            while (wake_o !== 1'b1 && n < 20) begin
                @(posedge clk_i);
                n++;
            end
            chk("wake", 32'h1, 32'(wake_o));
            chk("hib cleared", 32'h0, 32'(hib_mode_o));
            want <= 16'h0;
            tick(6);
            xfer(`WKES_OFS_STATUS, 1'b1, 32'hffff);
        end
        xfer(`WKES_OFS_HIBCTL, 1'b1, 32'h2);
        chk("hib refused", 32'h0, 32'(hib_mode_o));
        pulse(15);
        xfer(`WKES_OFS_MASK, 1'b1, 32'h8000);
        tick(2);
        chk("irq", 32'h1, 32'(irq_o));
        xfer(`WKES_OFS_MASK, 1'b1, 32'h0);
        tick(2);
        chk("irq masked", 32'h0, 32'(irq_o));
        xfer(`WKES_OFS_MASK, 1'b1, 32'h8000);
        tick(2);
        chk("irq", 32'h1, 32'(irq_o));
        xfer(`WKES_OFS_STATUS, 1'b1, 32'h8000);
        tick(2);
        chk("irq cleared", 32'h0, 32'(irq_o));
        xfer(`WKES_OFS_ENABLE, 1'b1, 32'h3e00);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        rd_chk("kept", `WKES_OFS_ENABLE, 32'h3e00);
        por_i <= 1'b1;
        resume_i <= 1'b0;
        tick(4);
        por_i <= 1'b0;
        tick(1);
        rd_chk("restored", `WKES_OFS_ENABLE, 32'h3e00);
        por_i <= 1'b1;
        resume_i <= 1'b1;
        tick(4);
        por_i <= 1'b0;
        tick(1);
        rd_chk("resume", `WKES_OFS_ENABLE, 32'h0);
        close_out();
    end
endmodule // wkes_top_test
